// [hdl/pit_pkg.sv]
// Package: register map, field positions, reset values and rates of the periodic interrupt timer
package pit_pkg;
    // Register offsets on the plain register port
    localparam logic [1:0] PIT_OFS_IRQ_ENABLE = 2'h0;
    localparam logic [1:0] PIT_OFS_EVENT_FLAGS = 2'h1;
    localparam logic [1:0] PIT_OFS_ACC_CTRL = 2'h2;
    localparam int PIT_ADDR_W = 2;
    // Event bits shared by the enable and flag registers, the enable prescale field and the control rate field
    localparam int PIT_BIT_WRAP = 7;
    localparam int PIT_BIT_TICK = 6;
    localparam int PIT_BIT_ACC_WRAP = 5;
    localparam int PIT_BIT_ACC_EDGE = 4;
    localparam int PIT_BIT_PRESCALE_HI = 1;
    localparam int PIT_BIT_PRESCALE_LO = 0;
    localparam int PIT_BIT_RATE_HI = 1;
    localparam int PIT_BIT_RATE_LO = 0;
    // Accumulator control fields: counter enable, edge polarity and an unused mode bit
    localparam int PIT_BIT_ACC_MODE = 5;
    localparam int PIT_BIT_ACC_ENABLE = 6;
    localparam int PIT_BIT_ACC_EDGE_POL = 4;
    // Implemented bits of the enable and flag registers
    localparam logic [7:0] PIT_ENABLE_MASK = 8'hF3;
    localparam logic [7:0] PIT_FLAG_MASK = 8'hF0;
    // Reset values
    localparam logic [7:0] PIT_RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] PIT_RST_EVENT_FLAGS = 8'h00;
    localparam logic [7:0] PIT_RST_ACC_CTRL = 8'h00;
    // Base division of the periodic tick and the widest total division
    localparam int PIT_TICK_BASE_LOG2 = 13;
    localparam int PIT_TICK_MAX_LOG2 = 16;
    // Window after reset during which the prescale field may be written once
    localparam int PIT_PRESCALE_WINDOW = 64;
endpackage

// [hdl/pit_tick_div.sv]
// Free-running divider that produces the periodic tick
`timescale 1ns/10ps
module pit_tick_div #(
    parameter int BASE_LOG2 = pit_pkg::PIT_TICK_BASE_LOG2, // Base division exponent
    parameter int MAX_LOG2 = pit_pkg::PIT_TICK_MAX_LOG2 // Widest division exponent
) (
    input wire logic clk_sys, // System clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic [1:0] rate_sel, // Extra division select
    output logic tick // One-cycle pulse at each timeout
);
    import pit_pkg::*;

    typedef struct packed {
        logic [MAX_LOG2-1:0] count;
        logic tick;
    } pit_div_state_t;

    pit_div_state_t state;
    pit_div_state_t next_state;
    logic [MAX_LOG2-1:0] period_mask;

    // Only reset touches the count, so software changes the spacing only through rate_sel
    always_comb begin
        next_state = state;
        period_mask = {MAX_LOG2{1'b1}} >> (MAX_LOG2 - BASE_LOG2 - int'(rate_sel));
        next_state.count = state.count + 1'b1;
        // Timeout when the low bits of the period are all ones; the next interval runs from here
        next_state.tick = ((state.count & period_mask) == period_mask);
    end

    // State register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;
endmodule

// [hdl/pit_acc_events.sv]
// Pulse accumulator count and input edge events feeding the flag logic
`timescale 1ns/10ps
module pit_acc_events (
    input wire logic clk_sys, // System clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic acc_pin, // Accumulator input pin, asynchronous
    input wire logic acc_enable, // Accumulator enabled
    input wire logic edge_rising, // Active edge is rising
    output logic edge_event, // One-cycle pulse on the active edge
    output logic wrap_event // One-cycle pulse when the count rolls over
);
    import pit_pkg::*;

    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic last;
        logic [7:0] count;
        logic edge_event;
        logic wrap_event;
    } pit_acc_state_t;

    pit_acc_state_t state;
    pit_acc_state_t next_state;
    logic hit;

    // Pin passes two flops; only the second is compared against the last level
    always_comb begin
        next_state = state;
        next_state.sync_a = acc_pin;
        next_state.sync_b = state.sync_a;
        next_state.last = state.sync_b;
        hit = edge_rising ? (state.sync_b & ~state.last) : (~state.sync_b & state.last);
        next_state.edge_event = hit;
        next_state.wrap_event = 1'b0;
        if (hit && acc_enable) begin
            next_state.count = state.count + 8'h01;
            next_state.wrap_event = (state.count == 8'hFF);
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign edge_event = state.edge_event;
    assign wrap_event = state.wrap_event;
endmodule

// [hdl/pit_top.sv]
// Periodic interrupt timer with shared enable, flag and accumulator control registers
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module pit_top #(
    parameter int PRESCALE_WINDOW = pit_pkg::PIT_PRESCALE_WINDOW // Cycles allowed for the prescale write
) (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic [pit_pkg::PIT_ADDR_W-1:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, one cycle after the strobe
    input wire logic acc_pin, // Accumulator input pin
    input wire logic special_mode, // High lifts the once-only prescale limit
    output logic irq_req, // Interrupt request, active high
    output logic [1:0] count_prescale_select, // Prescale select for the main counter
    output logic [15:0] free_running_count // Main free-running counter value
);
    import pit_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [7:0] enables;
        logic [7:0] flags;
        logic [7:0] acc_ctrl;
        logic [7:0] rdata;
        logic [6:0] window_cnt;
        logic prescale_done;
        logic mode_sync_a;
        logic mode_sync_b;
        logic [3:0] pre_cnt;
        logic [15:0] count;
        logic irq;
    } pit_state_t;

    pit_state_t state;
    pit_state_t next_state;
    logic tick;
    logic acc_edge_event;
    logic acc_wrap_event;
    logic wrap_event;
    logic [3:0] pre_limit;
    logic [7:0] set_bits;
    logic [7:0] clr_bits;
    logic pre_step;
    logic wr_en;
    logic wr_fl;
    logic wr_ac;

    ////////////////////////////////////////////////////////////////////////////
    // Sub-blocks

    // Tick divider reads the rate straight from the control register
    pit_tick_div u_tick (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .rate_sel(state.acc_ctrl[PIT_BIT_RATE_HI:PIT_BIT_RATE_LO]),
        .tick(tick)
    );

    // Accumulator events
    pit_acc_events u_acc (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .acc_pin(acc_pin),
        .acc_enable(state.acc_ctrl[PIT_BIT_ACC_ENABLE]),
        .edge_rising(state.acc_ctrl[PIT_BIT_ACC_EDGE_POL]),
        .edge_event(acc_edge_event),
        .wrap_event(acc_wrap_event)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Prescaler ratio: 1, 4, 8 or 16 clocks per count
    always_comb begin
        unique case (state.enables[PIT_BIT_PRESCALE_HI:PIT_BIT_PRESCALE_LO])
            2'h0: pre_limit = 4'h0;
            2'h1: pre_limit = 4'h3;
            2'h2: pre_limit = 4'h7;
            2'h3: pre_limit = 4'hF;
        endcase
    end

    assign pre_step = (state.pre_cnt == pre_limit);
    assign wrap_event = pre_step && (state.count == 16'hFFFF);
    assign wr_en = reg_wr && (reg_addr == PIT_OFS_IRQ_ENABLE);
    assign wr_fl = reg_wr && (reg_addr == PIT_OFS_EVENT_FLAGS);
    assign wr_ac = reg_wr && (reg_addr == PIT_OFS_ACC_CTRL);

    // Event sets ignore the enables so polling works
    always_comb begin
        set_bits = 8'h00;
        set_bits[PIT_BIT_WRAP] = wrap_event;
        set_bits[PIT_BIT_TICK] = tick;
        set_bits[PIT_BIT_ACC_WRAP] = acc_wrap_event;
        set_bits[PIT_BIT_ACC_EDGE] = acc_edge_event;
        clr_bits = wr_fl ? (reg_wdata & PIT_FLAG_MASK) : 8'h00;
    end

    // Registers, counters and request
    always_comb begin
        next_state = state;
        // Mode pin is asynchronous; only the second flop is read
        next_state.mode_sync_a = special_mode;
        next_state.mode_sync_b = state.mode_sync_a;
        // Main counter with prescaler; never touched by software
        next_state.pre_cnt = pre_step ? 4'h0 : (state.pre_cnt + 4'h1);
        if (pre_step) begin
            next_state.count = state.count + 16'h0001;
        end
        // Write-one-to-clear; a set in the same cycle wins
        next_state.flags = ((state.flags & ~clr_bits) | set_bits) & PIT_FLAG_MASK;
        // Window counter saturates once the prescale write window has passed
        if (int'(state.window_cnt) < PRESCALE_WINDOW) begin
            next_state.window_cnt = state.window_cnt + 7'h01;
        end
        if (wr_en) begin
            next_state.enables[7:4] = reg_wdata[7:4];
            // One write in normal mode, only inside the window; later ones are dropped
            if (state.mode_sync_b || (!state.prescale_done && int'(state.window_cnt) < PRESCALE_WINDOW)) begin
                next_state.enables[PIT_BIT_PRESCALE_HI:PIT_BIT_PRESCALE_LO] = reg_wdata[1:0];
                next_state.prescale_done = 1'b1;
            end
        end
        if (wr_ac) begin
            next_state.acc_ctrl = reg_wdata;
        end
        // Read data holds only in the cycle after the strobe
        next_state.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                PIT_OFS_IRQ_ENABLE: next_state.rdata = state.enables & PIT_ENABLE_MASK;
                PIT_OFS_EVENT_FLAGS: next_state.rdata = state.flags & PIT_FLAG_MASK;
                PIT_OFS_ACC_CTRL: next_state.rdata = state.acc_ctrl;
                default: next_state.rdata = 8'h00;
            endcase
        end
        // Request from updated flags and enables, so a clearing write of either drops it at once
        next_state.irq = |(next_state.flags & next_state.enables & PIT_FLAG_MASK);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
            state.enables <= PIT_RST_IRQ_ENABLE;
            state.flags <= PIT_RST_EVENT_FLAGS;
            state.acc_ctrl <= PIT_RST_ACC_CTRL;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata = state.rdata;
    assign irq_req = state.irq;
    assign count_prescale_select = state.enables[PIT_BIT_PRESCALE_HI:PIT_BIT_PRESCALE_LO];
    assign free_running_count = state.count;
endmodule

// [sim/pit_chk.sv]
// Port checker for the periodic interrupt timer
`timescale 1ns/10ps
module pit_chk #(
    parameter int PRESCALE_WINDOW = 64 // Prescale write window
) (
    input wire logic clk_sys, // Clock
    input wire logic arst_n, // Reset, active low
    input wire logic [pit_pkg::PIT_ADDR_W-1:0] reg_addr, // Address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic acc_pin, // Accumulator pin
    input wire logic special_mode, // Special mode
    input wire logic irq_req, // Request
    input wire logic [1:0] count_prescale_select, // Prescale
    input wire logic [15:0] free_running_count // Counter
);
    import pit_pkg::*;
    int age;
    // Saturating age since reset, so the lock check never wraps
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            age <= 0;
        end else if (age < 255) begin
            age <= age + 1;
        end
    end
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////
    property p_unmap; reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_flag_low; reg_rd && reg_addr == PIT_OFS_EVENT_FLAGS |=> reg_rdata[3:0] == 4'h0; endproperty
    a_flag_low: assert property (p_flag_low) else $error("flag low bits not zero");
    property p_en_gap; reg_rd && reg_addr == PIT_OFS_IRQ_ENABLE |=> reg_rdata[3:2] == 2'h0; endproperty
    a_en_gap: assert property (p_en_gap) else $error("enable gap bits not zero");
    property p_rate_rb;
        reg_wr && reg_addr == PIT_OFS_ACC_CTRL ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == PIT_OFS_ACC_CTRL
        |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_rate_rb: assert property (p_rate_rb) else $error("control readback wrong");
    // Late prescale writes must not move the field
    property p_pre_lock; age > PRESCALE_WINDOW + 2 && !special_mode |=> $stable(count_prescale_select); endproperty
    a_pre_lock: assert property (p_pre_lock) else $error("prescale changed late");
    property p_irq_fall; $fell(irq_req) |-> $past(reg_wr) && !$past(reg_addr[1]); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("request dropped without write");
    property p_irq_hold; irq_req && !reg_wr |=> irq_req; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("request dropped");
    property p_mask; reg_wr && reg_addr == PIT_OFS_IRQ_ENABLE && reg_wdata[7:4] == 4'h0 |=> !irq_req; endproperty
    a_mask: assert property (p_mask) else $error("masked request seen");
    property p_wrap; free_running_count == 16'hFFFF && count_prescale_select == 2'h0 |=> free_running_count == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter wrap wrong");
    c_irq: cover property ($rose(irq_req));
    c_unmap: cover property (reg_rd && reg_addr == 2'h3);
    c_wrap: cover property (free_running_count == 16'hFFFF);
endmodule
bind pit_top pit_chk #(.PRESCALE_WINDOW(PRESCALE_WINDOW)) u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acc_pin(acc_pin), .special_mode(special_mode), .irq_req(irq_req),
    .count_prescale_select(count_prescale_select), .free_running_count(free_running_count));

// [sim/tb_top.sv]
// Self-checking bench for the periodic interrupt timer
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    import pit_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [PIT_ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic acc_pin = 1'b0;
    logic special_mode = 1'b0;
    logic [7:0] reg_rdata;
    logic irq_req;
    logic [1:0] count_prescale_select;
    logic [15:0] free_running_count;
    int failures = 0;
    int comparisons = 0;
    int cyc = 0;
    int seen = 0;
    int t0 = 0;
    logic [7:0] d;
    // Short prescale window keeps the lock test quick
    pit_top #(.PRESCALE_WINDOW(8)) DUT (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_pin(acc_pin),
        .special_mode(special_mode), .irq_req(irq_req), .count_prescale_select(count_prescale_select),
        .free_running_count(free_running_count));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // Edges since reset release
    always @(posedge clk_sys) begin
        if (arst_n) cyc <= cyc + 1;
    end
    ////////////////////////////////////////////////////////////////
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        // Idle edge so a following write never re-drives the strobe in the same step
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [1:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge clk_sys);
    endtask
    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Bounded wait for the request; the edge is kept in seen
    task automatic wait_irq();
        repeat (70000) begin
            @(posedge clk_sys);
            #1;
            seen = cyc;
            if (irq_req === 1'b1) return;
        end
        failures++;
        finish_test();
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic s_reset();
        for (int a = 0; a < 4; a++) begin
            rd(a[1:0]);
            `CHK("reset value", 8'h00, d)
        end
        repeat (16) @(posedge clk_sys);
        wr(PIT_OFS_IRQ_ENABLE, 8'h03);
        rd(PIT_OFS_IRQ_ENABLE);
        `CHK("late prescale", 2'h0, count_prescale_select)
    endtask
    // Late clear must not restart the interval
    task automatic s_tick(input logic [7:0] ctl, input int per);
        wr(PIT_OFS_ACC_CTRL, ctl);
        wr(PIT_OFS_EVENT_FLAGS, 8'hF0);
        wait_irq();
        t0 = seen;
        repeat (300) @(posedge clk_sys);
        wr(PIT_OFS_EVENT_FLAGS, 8'h40);
        rd(PIT_OFS_EVENT_FLAGS);
        `CHK("tick cleared", 1'b0, d[6])
        wait_irq();
        `CHK("tick period", per, seen - t0)
    endtask
    task automatic s_poll();
        wr(PIT_OFS_IRQ_ENABLE, 8'h00);
        wr(PIT_OFS_ACC_CTRL, 8'h10);
        wr(PIT_OFS_EVENT_FLAGS, 8'hF0);
        while (cyc < 65600) @(posedge clk_sys);
        #1;
        `CHK("masked request", 1'b0, irq_req)
        rd(PIT_OFS_EVENT_FLAGS);
        `CHK("polled flags", 8'hC0, d)
        wr(PIT_OFS_IRQ_ENABLE, 8'h80);
        `CHK("wrap request", 1'b1, irq_req)
        wr(PIT_OFS_IRQ_ENABLE, 8'h40);
        wr(PIT_OFS_EVENT_FLAGS, 8'h8F);
        rd(PIT_OFS_EVENT_FLAGS);
        `CHK("partial clear", 8'h40, d)
        `CHK("tick request", 1'b1, irq_req)
        wr(PIT_OFS_EVENT_FLAGS, 8'h40);
        rd(PIT_OFS_EVENT_FLAGS);
        `CHK("request off", 1'b0, irq_req)
    endtask
    task automatic s_acc();
        wr(PIT_OFS_IRQ_ENABLE, 8'h30);
        wr(PIT_OFS_ACC_CTRL, 8'h50);
        repeat (256) begin
            acc_pin <= 1'b1;
            repeat (3) @(posedge clk_sys);
            acc_pin <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
        repeat (8) @(posedge clk_sys);
        rd(PIT_OFS_EVENT_FLAGS);
        `CHK("acc flags", 2'h3, d[5:4])
        `CHK("acc request", 1'b1, irq_req)
        // Falling polarity: a rise must not count, the following fall must
        wr(PIT_OFS_ACC_CTRL, 8'h40);
        wr(PIT_OFS_EVENT_FLAGS, 8'h30);
        acc_pin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(PIT_OFS_EVENT_FLAGS);
        `CHK("rise ignored", 1'b0, d[4])
        acc_pin <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rd(PIT_OFS_EVENT_FLAGS);
        `CHK("fall edge", 1'b1, d[4])
    endtask
    // Second reset: early prescale write lands once, later ones only in special mode
    task automatic s_prescale();
        arst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        wr(PIT_OFS_IRQ_ENABLE, 8'h02);
        rd(PIT_OFS_IRQ_ENABLE);
        `CHK("early prescale", 8'h02, d)
        wr(PIT_OFS_IRQ_ENABLE, 8'h01);
        rd(PIT_OFS_IRQ_ENABLE);
        `CHK("second prescale", 2'h2, count_prescale_select)
        special_mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        wr(PIT_OFS_IRQ_ENABLE, 8'h01);
        `CHK("special prescale", 2'h1, count_prescale_select)
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        s_reset();
        wr(PIT_OFS_IRQ_ENABLE, 8'h40);
        wait_irq();
        `CHK("first tick", 1'b1, seen >= 8192 && seen <= 8196)
        rd(PIT_OFS_EVENT_FLAGS);
        `CHK("tick flag", 8'h40, d)
        s_tick(8'h10, 8192);
        s_tick(8'h11, 16384);
        for (int r = 2; r < 4; r++) begin
            wr(PIT_OFS_ACC_CTRL, 8'h10 | 8'(r));
            rd(PIT_OFS_ACC_CTRL);
            `CHK("rate field", 8'h10 | 8'(r), d)
        end
        s_poll();
        s_acc();
        s_prescale();
        finish_test();
    end
endmodule
